// ---- src/ltrs_consts.svh ----
`ifndef LTRS_CONSTS_SVH
`define LTRS_CONSTS_SVH

// clock and tick
`define LTRS_CLK_HZ           250000000
`define LTRS_TICK_S           1
`define LTRS_TICK_CYCLES      (`LTRS_CLK_HZ * `LTRS_TICK_S)

// timer ranges and defaults, seconds
`define LTRS_BUSY_DEF_S       120
`define LTRS_ACK2_MIN_S       10
`define LTRS_ACK2_MAX_S       1800
`define LTRS_ACK2_DEF_S       120
`define LTRS_POLL_MIN_S       10
`define LTRS_POLL_MAX_S       60
`define LTRS_POLL_DEF_S       10
`define LTRS_ACK1_DEF_S       30
`define LTRS_PHY_DELAY_DEF_S  0

// retry limit
`define LTRS_RETRY_MAX        5
`define LTRS_RETRY_DEF        2

// minimum frame length, octets
`define LTRS_MIN_FRAME_OCTETS 9

`endif

// ---- src/ltrs_pkg.sv ----
package ltrs_pkg;

  typedef logic [11:0] ltrs_sec_t;

  typedef struct packed {
    ltrs_sec_t  ackTimeoutPeriod;
    ltrs_sec_t  phyDelay;
    ltrs_sec_t  busyTime;
    logic [2:0] connlessRetryLimit;
    logic       quietMode;
    ltrs_sec_t  ackTime;
    ltrs_sec_t  pollTime;
    ltrs_sec_t  rejTime;
  } ltrs_cfg_t;

  typedef struct packed {
    logic ack1;
    logic busy;
    logic ack2;
    logic poll;
    logic rej;
  } ltrs_ev_t;

  typedef enum logic [3:0] {
    LTRS_IDLE  = 4'h1,
    LTRS_WAIT  = 4'h2,
    LTRS_RETRY = 4'h4,
    LTRS_FAIL  = 4'h8
  } ltrs_cl_state_t;

endpackage : ltrs_pkg

// ---- src/ltrs_supervisor.sv ----
// Function
// - per-destination connectionless acknowledgement timeout runs while awaiting that station's ack.
// - connectionless timeout includes a configured physical sublayer delay allowance.
// - after busy command received, wait up to busy interval, default 120 s.
// - retransmit UI/TEST after timeout at most retry limit times, 0..5, default 2.
// - quiet mode suppresses timeout-driven retransmissions.
// - connectionless frame valid only if at least 9 octets long.
// - connection ack timer bounds wait for I-frame ack or U-command response.
// - connection ack timer is 10..1800 s in 1 s steps, default 120.
// - after poll-bit command sent, time wait for final-bit reply.
// - poll timer is 10..60 s in 1 s steps, default 10.
// - after REJ/SREJ sent, time wait for reply with reject timer.
// - reject timer never exceeds twice the connection ack timer.
// - timers other than the busy timer (started on busy command receipt) start only when the guarded frame finished transmission.
// - limits and timer values loaded at initialization and held afterwards.
`timescale 1ns/1ps
`include "ltrs_consts.svh"

module ltrs_supervisor #(
  parameter int unsigned TICK_CYCLES = `LTRS_TICK_CYCLES,
  parameter int unsigned NUM_DEST    = 4,
  parameter int unsigned DEST_W      = 2
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  clkEn,
  // configuration, captured on init
  input  wire logic                  protoInit,
  input  wire ltrs_pkg::ltrs_cfg_t   cfgIn,
  // connectionless events
  input  wire logic                  clTxDone,
  input  wire logic [DEST_W-1:0]     clTxDest,
  input  wire logic                  clAckRx,
  input  wire logic [DEST_W-1:0]     clAckDest,
  input  wire logic                  busyCmdRx,
  input  wire logic                  busyClearRx,
  // frame length check
  input  wire logic                  frameEnd,
  input  wire logic [11:0]           frameOctets,
  // connection-oriented events
  input  wire logic                  ackTxDone,
  input  wire logic                  ackRx,
  input  wire logic                  pollTxDone,
  input  wire logic                  finalRx,
  input  wire logic                  rejTxDone,
  input  wire logic                  rejReplyRx,
  // outputs
  output ltrs_pkg::ltrs_cfg_t        cfgHeld,
  output logic                       cfgError,
  output logic [NUM_DEST-1:0]        clRetransmitReq,
  output logic [NUM_DEST-1:0]        clGiveUp,
  output logic [NUM_DEST-1:0]        clWaiting,
  output logic                       frameValid,
  output logic                       frameShort,
  output ltrs_pkg::ltrs_ev_t         expired,
  output ltrs_pkg::ltrs_ev_t         running
);
  import ltrs_pkg::*;

  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

  function automatic logic cfg_ok(input ltrs_cfg_t c);
    cfg_ok = (c.connlessRetryLimit <= 3'(`LTRS_RETRY_MAX))
           && (c.ackTime >= 12'(`LTRS_ACK2_MIN_S)) && (c.ackTime <= 12'(`LTRS_ACK2_MAX_S))
           && (c.pollTime >= 12'(`LTRS_POLL_MIN_S)) && (c.pollTime <= 12'(`LTRS_POLL_MAX_S))
           && ({1'b0, c.rejTime} <= {c.ackTime, 1'b0});
  endfunction : cfg_ok

  // one-second prescaler
  logic [PW-1:0] preCnt;
  logic          tick;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      preCnt <= '0;
      tick   <= 1'b0;
    end else if (clkEn) begin
      tick <= 1'b0;
      if (preCnt == PW'(TICK_CYCLES - 1)) begin
        preCnt <= '0;
        tick   <= 1'b1;
      end else begin
        preCnt <= preCnt + 1'b1;
      end
    end
  end

  // configuration capture; bad set is refused, old values kept
  ltrs_cfg_t cfgDef;
  always_comb begin
    cfgDef                    = '0;
    cfgDef.ackTimeoutPeriod   = 12'(`LTRS_ACK1_DEF_S);
    cfgDef.phyDelay           = 12'(`LTRS_PHY_DELAY_DEF_S);
    cfgDef.busyTime           = 12'(`LTRS_BUSY_DEF_S);
    cfgDef.connlessRetryLimit = 3'(`LTRS_RETRY_DEF);
    cfgDef.ackTime            = 12'(`LTRS_ACK2_DEF_S);
    cfgDef.pollTime           = 12'(`LTRS_POLL_DEF_S);
    cfgDef.rejTime            = 12'(`LTRS_ACK2_DEF_S);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfgHeld  <= cfgDef;
      cfgError <= 1'b0;
    end else if (clkEn && protoInit) begin
      if (cfg_ok(cfgIn)) begin
        cfgHeld  <= cfgIn;
        cfgError <= 1'b0;
      end else begin
        cfgError <= 1'b1;
      end
    end
  end

  // minimum frame length check
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frameValid <= 1'b0;
      frameShort <= 1'b0;
    end else if (clkEn) begin
      frameValid <= frameEnd && (frameOctets >= 12'(`LTRS_MIN_FRAME_OCTETS));
      frameShort <= frameEnd && (frameOctets < 12'(`LTRS_MIN_FRAME_OCTETS));
    end
  end

  // per-destination connectionless supervision
  genvar d;
  generate
    for (d = 0; d < NUM_DEST; d++) begin : gDest
      ltrs_cl_state_t state;
      ltrs_sec_t      cnt;
      logic [2:0]     tries;
      logic           txHit;
      logic           ackHit;
      assign txHit  = clTxDone && (clTxDest == DEST_W'(d));
      assign ackHit = clAckRx && (clAckDest == DEST_W'(d));

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          state                 <= LTRS_IDLE;
          cnt                   <= '0;
          tries                 <= '0;
          clRetransmitReq[d]    <= 1'b0;
          clGiveUp[d]           <= 1'b0;
          clWaiting[d]          <= 1'b0;
        end else if (clkEn) begin
          clRetransmitReq[d] <= 1'b0;
          clGiveUp[d]        <= 1'b0;
          case (state)
            LTRS_IDLE: begin
              if (txHit) begin
                state        <= LTRS_WAIT;
                tries        <= '0;
                cnt          <= cfgHeld.ackTimeoutPeriod + cfgHeld.phyDelay;
                clWaiting[d] <= 1'b1;
              end
            end
            LTRS_WAIT: begin
              if (ackHit) begin
                state        <= LTRS_IDLE;
                clWaiting[d] <= 1'b0;
              end else if (tick) begin
                // expire on the tick after zero, so never short of the setting
                if (cnt == '0) begin
                  if (!cfgHeld.quietMode && tries < cfgHeld.connlessRetryLimit) begin
                    state              <= LTRS_RETRY;
                    tries              <= tries + 1'b1;
                    clRetransmitReq[d] <= 1'b1;
                  end else begin
                    state <= LTRS_FAIL;
                  end
                end else begin
                  cnt <= cnt - 1'b1;
                end
              end
            end
            LTRS_RETRY: begin
              if (ackHit) begin
                state        <= LTRS_IDLE;
                clWaiting[d] <= 1'b0;
              end else if (txHit) begin
                state <= LTRS_WAIT;
                cnt   <= cfgHeld.ackTimeoutPeriod + cfgHeld.phyDelay;
              end
            end
            LTRS_FAIL: begin
              state        <= LTRS_IDLE;
              clGiveUp[d]  <= 1'b1;
              clWaiting[d] <= 1'b0;
            end
            default: begin
              state <= LTRS_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // single-shot second timers: ack1 slot unused (per-destination above)
  ltrs_sec_t tLoad [5];
  logic      tStart [5];
  logic      tStop [5];
  ltrs_sec_t tCnt [5];

  always_comb begin
    tLoad[0]  = '0;
    tStart[0] = 1'b0;
    tStop[0]  = 1'b0;
    tLoad[1]  = cfgHeld.busyTime;
    tStart[1] = busyCmdRx;
    tStop[1]  = busyClearRx;
    tLoad[2]  = cfgHeld.ackTime;
    tStart[2] = ackTxDone;
    tStop[2]  = ackRx;
    tLoad[3]  = cfgHeld.pollTime;
    tStart[3] = pollTxDone;
    tStop[3]  = finalRx;
    tLoad[4]  = cfgHeld.rejTime;
    tStart[4] = rejTxDone;
    tStop[4]  = rejReplyRx;
  end

  genvar t;
  generate
    for (t = 1; t < 5; t++) begin : gTmr
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          tCnt[t]        <= '0;
          running[4-t]   <= 1'b0;
          expired[4-t]   <= 1'b0;
        end else if (clkEn) begin
          expired[4-t] <= 1'b0;
          if (tStart[t]) begin
            tCnt[t]      <= tLoad[t];
            running[4-t] <= 1'b1;
          end else if (tStop[t]) begin
            running[4-t] <= 1'b0;
          end else if (running[4-t] && tick) begin
            if (tCnt[t] == '0) begin
              running[4-t] <= 1'b0;
              expired[4-t] <= 1'b1;
            end else begin
              tCnt[t] <= tCnt[t] - 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ack1 bit reports any connectionless destination waiting, retransmitting or giving up
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      running.ack1 <= 1'b0;
      expired.ack1 <= 1'b0;
    end else if (clkEn) begin
      running.ack1 <= |clWaiting;
      expired.ack1 <= |(clRetransmitReq | clGiveUp);
    end
  end

endmodule : ltrs_supervisor

// ---- sim/ltrs_supervisor_properties.sv ----
`timescale 1ns/1ps
module ltrs_supervisor_properties
  import ltrs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned NUM_DEST    = 4,
  parameter int unsigned DEST_W      = 2
) (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire logic                clkEn,
  // stimulus
  input wire logic                protoInit,
  input wire ltrs_pkg::ltrs_cfg_t cfgIn,
  input wire logic                frameEnd,
  input wire logic [11:0]         frameOctets,
  input wire logic                ackTxDone,
  input wire logic                pollTxDone,
  input wire logic                rejTxDone,
  // results
  input wire ltrs_pkg::ltrs_cfg_t cfgHeld,
  input wire logic                cfgError,
  input wire logic [NUM_DEST-1:0] clRetransmitReq,
  input wire logic [NUM_DEST-1:0] clGiveUp,
  input wire logic                frameValid,
  input wire logic                frameShort,
  input wire ltrs_pkg::ltrs_ev_t  expired,
  input wire ltrs_pkg::ltrs_ev_t  running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  int unsigned ackCnt;
  // cycles the connection ack timer has run since its last start
  always_ff @(posedge sys_clk) begin
    if (srst || !running.ack2 || ackTxDone) ackCnt <= 0;
    else if (clkEn) ackCnt <= ackCnt + 1;
  end
  AST_FRAME_OK: assert property (frameEnd && clkEn && frameOctets >= 12'h009 |=> frameValid && !frameShort)
    else $error("long frame not accepted");
  AST_FRAME_SHORT: assert property (frameEnd && clkEn && frameOctets < 12'h009 |=> frameShort && !frameValid)
    else $error("short frame not refused");
  AST_CFG_REFUSE: assert property (protoInit && clkEn && cfgIn.connlessRetryLimit > 3'h5 |=> cfgError && $stable(cfgHeld))
    else $error("retry limit above five taken");
  AST_CFG_HOLD: assert property (!(protoInit && clkEn) |=> $stable(cfgHeld))
    else $error("held config changed without init");
  AST_REJ_CAP: assert property ({1'b0, cfgHeld.rejTime} <= {cfgHeld.ackTime, 1'b0})
    else $error("reject time above twice ack time");
  AST_POLL_START: assert property (pollTxDone && clkEn |=> running.poll)
    else $error("poll timer not started");
  AST_EXPIRE_ENDS: assert property (expired.poll |-> $past(running.poll) && !running.poll)
    else $error("poll expiry without running timer");
  AST_REJ_CAUSE: assert property ($rose(running.rej) |-> $past(rejTxDone))
    else $error("reject timer started without sent frame");
  AST_QUIET: assert property (|clRetransmitReq |-> !cfgHeld.quietMode && !(|(clRetransmitReq & clGiveUp)))
    else $error("retransmit in quiet mode");
  AST_ACK2_BOUND: assert property (ackCnt <= (cfgHeld.ackTime + 1) * TICK_CYCLES + 2)
    else $error("ack timer overran its setting");
  cover property (expired.poll);
  cover property (|clGiveUp);
  cover property (cfgError);
endmodule : ltrs_supervisor_properties

bind ltrs_supervisor ltrs_supervisor_properties #(
  .TICK_CYCLES(TICK_CYCLES),
  .NUM_DEST(NUM_DEST),
  .DEST_W(DEST_W)
) i_props (
  .sys_clk(sys_clk),
  .srst(srst),
  .clkEn(clkEn),
  .protoInit(protoInit),
  .cfgIn(cfgIn),
  .frameEnd(frameEnd),
  .frameOctets(frameOctets),
  .ackTxDone(ackTxDone),
  .pollTxDone(pollTxDone),
  .rejTxDone(rejTxDone),
  .cfgHeld(cfgHeld),
  .cfgError(cfgError),
  .clRetransmitReq(clRetransmitReq),
  .clGiveUp(clGiveUp),
  .frameValid(frameValid),
  .frameShort(frameShort),
  .expired(expired),
  .running(running)
);

// ---- sim/ltrs_remote_station.sv ----
`timescale 1ns/1ps
module ltrs_remote_station #(
  parameter int unsigned DEST_W = 2
) (
  // clock and mode
  input wire logic              sys_clk,
  input wire logic              reply,
  // frames finished locally
  input wire logic              clTxDone,
  input wire logic [DEST_W-1:0] clTxDest,
  input wire logic              ackTxDone,
  input wire logic              pollTxDone,
  input wire logic              rejTxDone,
  // answers from the far end
  output logic                  clAckRx,
  output logic [DEST_W-1:0]     clAckDest,
  output logic                  ackRx,
  output logic                  finalRx,
  output logic                  rejReplyRx
);
  logic [3:0]        s0 = '0, s1 = '0, out = '0;
  logic [DEST_W-1:0] lastDest = '0;
  // two cycle turnaround, answers driven off the falling edge
  always @(posedge sys_clk) begin
    s0 <= {rejTxDone, pollTxDone, ackTxDone, clTxDone} & {4{reply}};
    s1 <= s0;
    if (clTxDone) lastDest <= clTxDest;
  end
  always @(negedge sys_clk) out <= s1;
  assign {rejReplyRx, finalRx, ackRx, clAckRx} = out;
  // address is junk outside the strobe
  assign clAckDest = clAckRx ? lastDest : ~lastDest;
endmodule : ltrs_remote_station

// ---- sim/ltrs_supervisor_tb.sv ----
`timescale 1ns/1ps
module ltrs_supervisor_tb;
  import ltrs_pkg::*;
  localparam ltrs_cfg_t DEF  = '{12'h01E, 12'h000, 12'h078, 3'h2, 1'h0, 12'h078, 12'h00A, 12'h078};
  localparam ltrs_cfg_t GOOD = '{12'h001, 12'h002, 12'h003, 3'h1, 1'h0, 12'h00A, 12'h00A, 12'h014};
  logic       sys_clk = 0, srst = 1, clkEn = 1, protoInit = 0, reply = 0;
  logic [6:0] ev = '0;
  logic [1:0] clTxDest = '0, clAckDest;
  logic [11:0] frameOctets = '0;
  ltrs_cfg_t  cfgIn = DEF, cfgHeld, c;
  logic       clAckRx, ackRx, finalRx, rejReplyRx, cfgError, frameValid, frameShort;
  logic [3:0] clRetransmitReq, clGiveUp, clWaiting;
  ltrs_ev_t   expired, running;
  int         nFail = 0, samplesChecked = 0, cyc = 0;
  wire clTxDone = ev[0], busyCmdRx = ev[1], busyClearRx = ev[2], frameEnd = ev[3];
  wire ackTxDone = ev[4], pollTxDone = ev[5], rejTxDone = ev[6];
  wire [8:0] watch = {frameShort, frameValid, |clGiveUp, |clRetransmitReq, expired};
  always #2 sys_clk = ~sys_clk;
  ltrs_supervisor #(.TICK_CYCLES(4)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .protoInit(protoInit), .cfgIn(cfgIn),
    .clTxDone(clTxDone), .clTxDest(clTxDest), .clAckRx(clAckRx), .clAckDest(clAckDest),
    .busyCmdRx(busyCmdRx), .busyClearRx(busyClearRx), .frameEnd(frameEnd), .frameOctets(frameOctets),
    .ackTxDone(ackTxDone), .ackRx(ackRx), .pollTxDone(pollTxDone), .finalRx(finalRx),
    .rejTxDone(rejTxDone), .rejReplyRx(rejReplyRx), .cfgHeld(cfgHeld), .cfgError(cfgError),
    .clRetransmitReq(clRetransmitReq), .clGiveUp(clGiveUp), .clWaiting(clWaiting),
    .frameValid(frameValid), .frameShort(frameShort), .expired(expired), .running(running)
  );
  ltrs_remote_station i_far (
    .sys_clk(sys_clk), .reply(reply), .clTxDone(clTxDone), .clTxDest(clTxDest), .ackTxDone(ackTxDone),
    .pollTxDone(pollTxDone), .rejTxDone(rejTxDone), .clAckRx(clAckRx), .clAckDest(clAckDest),
    .ackRx(ackRx), .finalRx(finalRx), .rejReplyRx(rejReplyRx)
  );
  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic fire(input int b);
    @(negedge sys_clk);
    ev[b] = 1'b1;
    @(negedge sys_clk);
    ev = '0;
  endtask : fire
  task automatic init(input ltrs_cfg_t v);
    @(negedge sys_clk);
    cfgIn = v;
    protoInit = 1'b1;
    @(negedge sys_clk);
    protoInit = 1'b0;
  endtask : init
  // cycles until an output event, inside a window
  task automatic waitBit(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (watch[b] !== 1'b1 && n <= hi) begin
      @(negedge sys_clk);
      n++;
    end
    chk("eventDelay", 1'b1, n >= lo && n <= hi);
  endtask : waitBit
  task conclude;
    if (nFail == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    srst = 0;
    chk("cfgHeld", DEF, cfgHeld);
    chk("cfgError", 0, cfgError);
    init(GOOD);
    chk("cfgHeld", GOOD, cfgHeld);
    for (int i = 0; i < 6; i++) begin
      c = GOOD;
      case (i)
        0: c.connlessRetryLimit = 3'h6;
        1: c.ackTime = 12'h009;
        2: c.ackTime = 12'h709;
        3: c.pollTime = 12'h03D;
        4: c.pollTime = 12'h009;
        default: c.rejTime = 12'h015;
      endcase
      init(c);
      chk("cfgError", 1, cfgError);
      chk("cfgHeld", GOOD, cfgHeld);
    end
    frameOctets = 12'h008;
    fire(3);
    waitBit(8, 0, 1);
    frameOctets = 12'h009;
    fire(3);
    waitBit(7, 0, 1);
    clkEn = 0;
    frameOctets = 12'h008;
    fire(3);
    chk("frameShort", 0, frameShort);
    clkEn = 1;
    fire(5);
    waitBit(1, 39, 46);
    fire(6);
    waitBit(0, 79, 86);
    fire(1);
    waitBit(3, 11, 18);
    fire(1);
    fire(2);
    chk("busyRunning", 0, running.busy);
    reply = 1;
    fire(4);
    fire(5);
    fire(6);
    repeat (6) @(negedge sys_clk);
    chk("ack2Running", 0, running.ack2);
    chk("pollRunning", 0, running.poll);
    chk("rejRunning", 0, running.rej);
    reply = 0;
    fire(4);
    waitBit(2, 39, 46);
    clTxDest = 2'h1;
    fire(0);
    waitBit(5, 11, 18);
    fire(0);
    waitBit(6, 11, 19);
    reply = 1;
    fire(0);
    repeat (6) @(negedge sys_clk);
    chk("clWaiting", 0, clWaiting);
    reply = 0;
    c = GOOD;
    c.quietMode = 1'b1;
    init(c);
    chk("cfgError", 0, cfgError);
    fire(0);
    @(negedge sys_clk);
    chk("waitAny", 1, running.ack1);
    waitBit(6, 11, 19);
    waitBit(4, 1, 1);
    conclude();
  end
endmodule : ltrs_supervisor_tb
